// >>> common/adcrb_pkg.sv
// Shared constants and carriers for the converter result readback bank
package adcrb_pkg;

    // Register byte addresses on the serial register interface
    localparam logic [7:0] ADCRB_BAT_HI_OFS = 8'h1d;
    localparam logic [7:0] ADCRB_BAT_LO_OFS = 8'h1e;
    localparam logic [7:0] ADCRB_SYS_HI_OFS = 8'h1f;
    localparam logic [7:0] ADCRB_SYS_LO_OFS = 8'h20;
    localparam logic [7:0] ADCRB_TS_HI_OFS = 8'h21;
    localparam logic [7:0] ADCRB_TS_LO_OFS = 8'h22;

    // Value of every field after reset and after register reset
    localparam logic [7:0] ADCRB_RESET_VAL = 8'h00;
    localparam logic [15:0] ADCRB_WORD_RESET = 16'h0000;

    // Sign bit position of a result word
    localparam int ADCRB_SIGN_BIT = 15;

    // Thermistor code for 94.9 % of the regulator output (LSB 100/1024 %)
    localparam logic [15:0] ADCRB_TS_MAX_CODE = 16'h03cc;

    // Channel numbering
    localparam int ADCRB_NUM_CH = 3;
    localparam int ADCRB_CH_BAT = 0;
    localparam int ADCRB_CH_SYS = 1;
    localparam int ADCRB_CH_TS = 2;

    // One conversion result from the converter, valid for one cycle
    typedef struct packed {
        logic valid;
        logic [15:0] data;
    } adcrb_result_type;

    // Register read request from the serial interface logic
    typedef struct packed {
        logic en;
        logic [7:0] addr;
    } adcrb_rd_req_type;

    // True when a read request targets the given byte address
    function automatic logic adcrb_hit(input adcrb_rd_req_type req,
                                       input logic [7:0] ofs);
        return req.en && (req.addr == ofs);
    endfunction

endpackage

// >>> sim/adcrb_host_model.sv
`timescale 1ns/100ps
// Host side reader: one byte read per request pulse
module adcrb_host_model
    import adcrb_pkg::*;
(
    input wire logic clk_sys_i,
    output adcrb_rd_req_type rd_req_o,
    input wire logic [7:0] rd_data_i,
    input wire logic rd_valid_i
);
    // Idle until the first read
    initial begin
        rd_req_o = '0;
    end

    // Read one byte; the answer is awaited for a bounded number of cycles
    task automatic rd(input logic [7:0] addr, output logic [7:0] data,
                      output bit ok);
        int n;
        ok = 0;
        data = 8'h00;
        @(negedge clk_sys_i);
        rd_req_o = '{en: 1'b1, addr: addr};
        @(negedge clk_sys_i);
        // Released address is scrambled so a stale one is never reused
        rd_req_o = '{en: 1'b0, addr: ~addr};
        for (n = 0; n < 4 && !ok; n++) begin
            if (rd_valid_i === 1'b1) begin
                ok = 1;
                data = rd_data_i;
            end else begin
                @(negedge clk_sys_i);
            end
        end
    endtask
endmodule

// >>> sim/adcrb_regs_tb_top.sv
`timescale 1ns/100ps
// Compare one value, count it, report a mismatch at once
`define CHK(nm, exp, got) begin checks_done++; \
    if ((got) !== (exp)) begin bad_count++; \
    $display("wrong value %s exp %h got %h", nm, exp, got); end end

module adcrb_regs_tb_top
    import adcrb_pkg::*;
;
    logic clk = 1'b0; // System clock
    logic reset_n = 1'b0; // Async reset, active low
    adcrb_result_type bat_res, sys_res, ts_res; // Converter results
    adcrb_rd_req_type rd_req; // Read request from host model
    logic [7:0] rd_data;
    logic rd_valid, done, restart, soft_reset;
    int bad_count = 0;
    int checks_done = 0;

    // 40 MHz clock
    always #12.5 clk = ~clk;

    adcrb_regs adcrb_regs_inst (
        .clk_sys_i(clk), .reset_n_i(reset_n),
        .bat_result_i(bat_res), .sys_result_i(sys_res),
        .ts_result_i(ts_res), .rd_req_i(rd_req),
        .soft_reset_i(soft_reset), .rd_data_o(rd_data),
        .rd_valid_o(rd_valid), .reg_rst_done_o(done),
        .safety_timer_restart_o(restart)
    );

    adcrb_host_model adcrb_host_model_inst (
        .clk_sys_i(clk), .rd_req_o(rd_req),
        .rd_data_i(rd_data), .rd_valid_i(rd_valid)
    );

    // Verdict and end of run
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Read one register and compare; a missing answer ends the run
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        bit ok;
        adcrb_host_model_inst.rd(a, d, ok);
        if (!ok) begin
            bad_count++;
            close_out();
        end else begin
            `CHK($sformatf("reg %h", a), exp, d)
        end
    endtask

    // High byte first, then low byte of one word
    task automatic word(input logic [7:0] a_hi, input logic [15:0] w);
        rchk(a_hi, w[15:8]);
        rchk(a_hi + 8'h01, w[7:0]);
    endtask

    // One-cycle result pulse on a channel
    task automatic load(input int ch, input logic [15:0] w);
        @(negedge clk);
        case (ch)
            ADCRB_CH_BAT: bat_res = '{valid: 1'b1, data: w};
            ADCRB_CH_SYS: sys_res = '{valid: 1'b1, data: w};
            default: ts_res = '{valid: 1'b1, data: w};
        endcase
        @(negedge clk);
        bat_res.valid = 1'b0;
        sys_res.valid = 1'b0;
        ts_res.valid = 1'b0;
    endtask

    // Main sequence
    initial begin
        bat_res = '0;
        sys_res = '0;
        ts_res = '0;
        soft_reset = 1'b0;
        repeat (16) @(negedge clk);
        reset_n = 1'b1;
        // Reset values, unmapped 0x23 included
        for (int a = 'h1d; a <= 'h23; a++) begin
            rchk(8'(a), ADCRB_RESET_VAL);
        end
        load(ADCRB_CH_BAT, 16'h8123);
        load(ADCRB_CH_SYS, 16'h7f55);
        load(ADCRB_CH_TS, 16'h0155);
        word(ADCRB_BAT_HI_OFS, 16'h8123);
        word(ADCRB_SYS_HI_OFS, 16'h7f55);
        word(ADCRB_TS_HI_OFS, 16'h0155);
        // Thermistor clamps at both ends
        load(ADCRB_CH_TS, 16'h0400);
        word(ADCRB_TS_HI_OFS, ADCRB_TS_MAX_CODE);
        load(ADCRB_CH_TS, 16'hffff);
        word(ADCRB_TS_HI_OFS, ADCRB_WORD_RESET);
        // New conversion between high and low reads
        rchk(ADCRB_SYS_HI_OFS, 8'h7f);
        load(ADCRB_CH_SYS, 16'h0a0b);
        rchk(ADCRB_SYS_LO_OFS, 8'h55);
        rchk(ADCRB_SYS_LO_OFS, 8'h0b);
        // Register reset
        @(negedge clk);
        soft_reset = 1'b1;
        @(negedge clk);
        soft_reset = 1'b0;
        `CHK("done", 1'b1, done)
        `CHK("restart", 1'b1, restart)
        @(negedge clk);
        `CHK("done off", 1'b0, done)
        for (int a = 'h1d; a <= 'h22; a++) begin
            rchk(8'(a), ADCRB_RESET_VAL);
        end
        close_out();
    end
endmodule

// >>> src/adcrb_pair.sv
`timescale 1ns/100ps
// One 16-bit result held as a high and low byte with a coherent snapshot
module adcrb_pair
    import adcrb_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic clear_i,
    input wire logic upd_i,
    input wire logic [15:0] upd_data_i,
    input wire logic hi_rd_i,
    input wire logic lo_rd_i,
    output logic [7:0] hi_o,
    output logic [7:0] lo_o
);
    logic [15:0] word_r;     // Live result
    logic [15:0] word_nxt;
    logic [7:0] shadow_r;    // Low byte frozen at a high byte read
    logic [7:0] shadow_nxt;
    logic pend_r;            // Snapshot waiting for the low byte read
    logic pend_nxt;

    // Next state of result, snapshot and pending flag
    always_comb begin
        word_nxt = word_r;
        shadow_nxt = shadow_r;
        pend_nxt = pend_r;
        if (clear_i) begin
            // Register reset wins over everything
            word_nxt = ADCRB_WORD_RESET;
            shadow_nxt = ADCRB_RESET_VAL;
            pend_nxt = 1'b0;
        end else begin
            if (upd_i) begin
                // Whole word replaced at once, sign bit kept
                word_nxt = upd_data_i;
            end
            if (hi_rd_i) begin
                // Freeze the partner half of this very word
                shadow_nxt = word_r[7:0];
                pend_nxt = 1'b1;
            end else if (lo_rd_i) begin
                pend_nxt = 1'b0;
            end
        end
    end

    // Registers
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            word_r <= ADCRB_WORD_RESET;
            shadow_r <= ADCRB_RESET_VAL;
            pend_r <= 1'b0;
        end else begin
            word_r <= word_nxt;
            shadow_r <= shadow_nxt;
            pend_r <= pend_nxt;
        end
    end

    // Byte views seen by the read mux
    assign hi_o = word_r[15:8];
    assign lo_o = pend_r ? shadow_r : word_r[7:0];

    a_pair_update: assert property (
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        upd_i && !clear_i |=> word_r == $past(upd_data_i))
        else $error("Result word not taken from converter");

    a_pair_coherent: assert property (
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        hi_rd_i && !clear_i
        |=> pend_r && lo_o == $past(word_r[7:0]))
        else $error("Low byte not frozen at high byte read");

    a_pair_hold: assert property (
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        pend_r && !hi_rd_i && !lo_rd_i && !clear_i
        |=> pend_r && lo_o == $past(lo_o))
        else $error("Frozen low byte changed before its read");

    a_pair_snapshot: assert property (
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        hi_rd_i && !clear_i ##1 upd_i && !clear_i && !lo_rd_i
        |=> lo_o == $past(word_r[7:0], 2))
        else $error("Low byte not from same conversion as high byte");

endmodule

// >>> src/adcrb_regs.sv
`timescale 1ns/100ps
// Summary of operation
// - Battery low byte at 0x1e, 1 mV LSB.
// - System high byte at 0x1f, 256 mV LSB.
// - System low byte at 0x20, 1 mV LSB.
// - Bit 15 is sign, two's complement.
// - Thermistor high byte 0x21, bits 14:10 unweighted.
// - Thermistor result spans 0 to 94.9 percent.
// - Read-only, reset 0x00, register reset clears.
// - Battery high byte at 0x1d, signed mV.
// - Thermistor low byte at 0x22, 12.5 percent MSB.
// - Register reset restores defaults, restarts timer, completes.
module adcrb_regs
    import adcrb_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire adcrb_result_type bat_result_i,
    input wire adcrb_result_type sys_result_i,
    input wire adcrb_result_type ts_result_i,
    input wire adcrb_rd_req_type rd_req_i,
    input wire logic soft_reset_i,
    output logic [7:0] rd_data_o,
    output logic rd_valid_o,
    output logic reg_rst_done_o,
    output logic safety_timer_restart_o
);
    // Byte addresses per channel
    localparam logic [7:0] HI_OFS [ADCRB_NUM_CH] =
        '{ADCRB_BAT_HI_OFS, ADCRB_SYS_HI_OFS, ADCRB_TS_HI_OFS};
    localparam logic [7:0] LO_OFS [ADCRB_NUM_CH] =
        '{ADCRB_BAT_LO_OFS, ADCRB_SYS_LO_OFS, ADCRB_TS_LO_OFS};

    adcrb_result_type res_in [ADCRB_NUM_CH]; // Per channel updates
    logic [15:0] ts_code;                   // Thermistor after range limit
    logic [7:0] hi_w [ADCRB_NUM_CH];        // High byte views
    logic [7:0] lo_w [ADCRB_NUM_CH];        // Low byte views
    logic [7:0] rd_data_r;                  // Read return byte
    logic [7:0] rd_data_nxt;
    logic rd_valid_r;                       // Read return strobe
    logic rd_valid_nxt;
    logic rst_done_r;                       // Register reset complete
    logic rst_done_nxt;

    // Limit thermistor code to its documented span
    always_comb begin
        if (ts_result_i.data[ADCRB_SIGN_BIT]) begin
            // Negative readings pinned at 0 %
            ts_code = ADCRB_WORD_RESET;
        end else if (ts_result_i.data > ADCRB_TS_MAX_CODE) begin
            // Above top of range pinned at 94.9 %
            ts_code = ADCRB_TS_MAX_CODE;
        end else begin
            ts_code = ts_result_i.data;
        end
    end

    // Route converter results to their pair holders
    always_comb begin
        res_in[ADCRB_CH_BAT] = bat_result_i;
        res_in[ADCRB_CH_SYS] = sys_result_i;
        res_in[ADCRB_CH_TS].valid = ts_result_i.valid;
        res_in[ADCRB_CH_TS].data = ts_code;
    end

    // One byte-pair holder per channel
    for (genvar ch = 0; ch < ADCRB_NUM_CH; ch++) begin : g_ch
        adcrb_pair u_pair (
            .clk_sys_i(clk_sys_i),
            .reset_n_i(reset_n_i),
            .clear_i(soft_reset_i),
            .upd_i(res_in[ch].valid),
            .upd_data_i(res_in[ch].data),
            .hi_rd_i(adcrb_hit(rd_req_i, HI_OFS[ch])),
            .lo_rd_i(adcrb_hit(rd_req_i, LO_OFS[ch])),
            .hi_o(hi_w[ch]),
            .lo_o(lo_w[ch])
        );
    end

    // Read mux, unmapped addresses return zero
    always_comb begin
        rd_data_nxt = ADCRB_RESET_VAL;
        rd_valid_nxt = rd_req_i.en;
        for (int ch = 0; ch < ADCRB_NUM_CH; ch++) begin
            if (adcrb_hit(rd_req_i, HI_OFS[ch])) begin
                // Upper byte: sign and high weights
                rd_data_nxt = hi_w[ch];
            end
            if (adcrb_hit(rd_req_i, LO_OFS[ch])) begin
                // Lower byte: 1 mV or 0.098 % steps
                rd_data_nxt = lo_w[ch];
            end
        end
        if (soft_reset_i) begin
            // Reads during register reset see the default
            rd_data_nxt = ADCRB_RESET_VAL;
        end
    end

    // Register reset handshake, done one cycle after the clear
    always_comb begin
        rst_done_nxt = soft_reset_i;
    end

    // Output registers
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rd_data_r <= ADCRB_RESET_VAL;
            rd_valid_r <= 1'b0;
            rst_done_r <= 1'b0;
        end else begin
            rd_data_r <= rd_data_nxt;
            rd_valid_r <= rd_valid_nxt;
            rst_done_r <= rst_done_nxt;
        end
    end

    // Top outputs come straight from the flops above
    assign rd_data_o = rd_data_r;
    assign rd_valid_o = rd_valid_r;
    assign reg_rst_done_o = rst_done_r;
    assign safety_timer_restart_o = rst_done_r;

    // Read path checks
    a_bat_lo_read: assert property (
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        adcrb_hit(rd_req_i, ADCRB_BAT_LO_OFS) && !soft_reset_i
        |=> rd_valid_o && rd_data_o == $past(lo_w[ADCRB_CH_BAT]))
        else $error("Battery low byte read wrong");

    a_sys_hi_read: assert property (
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        adcrb_hit(rd_req_i, ADCRB_SYS_HI_OFS) && !soft_reset_i
        |=> rd_data_o == $past(hi_w[ADCRB_CH_SYS]))
        else $error("System high byte read wrong");

    a_sys_lo_read: assert property (
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        adcrb_hit(rd_req_i, ADCRB_SYS_LO_OFS) && !soft_reset_i
        |=> rd_data_o == $past(lo_w[ADCRB_CH_SYS]))
        else $error("System low byte read wrong");

    // Result storage checks
    a_bat_word_sign: assert property (
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        bat_result_i.valid && !soft_reset_i
        |=> hi_w[ADCRB_CH_BAT] == $past(bat_result_i.data[15:8]))
        else $error("Battery high byte or sign lost");

    a_ts_upper_zero: assert property (
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        hi_w[ADCRB_CH_TS][7:2] == 6'h00)
        else $error("Thermistor unweighted bits set");

    a_ts_range: assert property (
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        ts_result_i.valid && !soft_reset_i
        && ts_result_i.data > ADCRB_TS_MAX_CODE
        && !ts_result_i.data[ADCRB_SIGN_BIT]
        |=> g_ch[ADCRB_CH_TS].u_pair.word_r == ADCRB_TS_MAX_CODE
            && hi_w[ADCRB_CH_TS] == ADCRB_TS_MAX_CODE[15:8])
        else $error("Thermistor result above 94.9 percent");

    // Register reset, unmapped read and remaining read path and storage checks
    a_soft_rst_clear: assert property (
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        soft_reset_i |=> hi_w[ADCRB_CH_BAT] == ADCRB_RESET_VAL
            && lo_w[ADCRB_CH_SYS] == ADCRB_RESET_VAL
            && lo_w[ADCRB_CH_TS] == ADCRB_RESET_VAL)
        else $error("Register reset did not clear results");

    a_unmapped_zero: assert property (
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        rd_req_i.en && (rd_req_i.addr < ADCRB_BAT_HI_OFS
            || rd_req_i.addr > ADCRB_TS_LO_OFS)
        |=> rd_valid_o && rd_data_o == ADCRB_RESET_VAL)
        else $error("Unmapped read not zero");

    a_bat_hi_read: assert property (
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        adcrb_hit(rd_req_i, ADCRB_BAT_HI_OFS) && !soft_reset_i
        |=> rd_data_o == $past(hi_w[ADCRB_CH_BAT]))
        else $error("Battery high byte read wrong");

    a_ts_lo_read: assert property (
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        adcrb_hit(rd_req_i, ADCRB_TS_LO_OFS) && !soft_reset_i
        |=> rd_data_o == $past(lo_w[ADCRB_CH_TS]))
        else $error("Thermistor low byte read wrong");

    a_rst_done_pulse: assert property (
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        soft_reset_i |=> reg_rst_done_o && safety_timer_restart_o
            ##1 (reg_rst_done_o == $past(soft_reset_i)))
        else $error("Register reset completion not signalled");

    a_ts_neg_zero: assert property (
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        ts_result_i.valid && !soft_reset_i
        && ts_result_i.data[ADCRB_SIGN_BIT]
        |=> g_ch[ADCRB_CH_TS].u_pair.word_r == ADCRB_WORD_RESET)
        else $error("Negative thermistor result not pinned at zero");

    a_bat_lo_update: assert property (
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        bat_result_i.valid && !soft_reset_i
        |=> g_ch[ADCRB_CH_BAT].u_pair.word_r[7:0]
            == $past(bat_result_i.data[7:0]))
        else $error("Battery low byte not taken from converter");

    a_rd_valid_follow: assert property (
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        rd_valid_o == $past(rd_req_i.en))
        else $error("Read strobe not one cycle after request");

    a_soft_rd_zero: assert property (
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        soft_reset_i && rd_req_i.en
        |=> rd_valid_o && rd_data_o == ADCRB_RESET_VAL)
        else $error("Read during register reset not zero");

endmodule
